// ===== hdl/eccc_top.sv
`include "eccc_defines.svh"

module eccc_top (
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  input  wire eccc_pkg::eccc_ctrl_s ctrl_i,
  input  wire eccc_pkg::eccc_cmp_wr_s cmp_wr_i,
  input  wire logic                 ovf_clear_i,
  input  wire logic                 ext_trigger_pin_i,
  output logic [15:0]               counter_o,
  output logic [15:0]               compare_reg_a_o,
  output logic [15:0]               shared_capcomp_reg_o,
  output logic [15:0]               dedicated_capture_reg_o,
  output logic                      overflow_flag_o,
  output logic                      match_irq_a_o,
  output logic                      match_irq_b_o,
  output logic                      edge_irq_o
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [9:0]  presc_reg;
  logic        started_reg;
  logic        clr_pend_reg;
  logic        run_d_reg;
  logic        edge_det;
  logic        cnt_clk;
  logic        int_tick;
  logic [15:0] max_val;
  logic        match_a;
  logic        match_b;
  logic        cap_clr;
  logic        irq_a_reg;
  logic        irq_b_reg;

  function automatic logic [9:0] presc_mask(input logic [3:0] sel);
    logic [9:0] m;
    m = 10'h000;
    unique case (sel)
      4'h0: m = 10'h003;
      4'h1: m = 10'h007;
      4'h2: m = 10'h00f;
      4'h3: m = 10'h01f;
      4'h4: m = 10'h03f;
      4'h5: m = 10'h07f;
      4'h6: m = 10'h0ff;
      4'h7: m = 10'h1ff;
      default: m = 10'h3ff;
    endcase
    return m;
  endfunction : presc_mask

  function automatic logic [15:0] width_mask(input logic [15:0] v, input logic wide);
    return wide ? v : (v & `ECCC_NARROW_MAX);
  endfunction : width_mask

  eccc_edge_detect u_edge (
    .mclk_i                 (mclk_i),
    .sys_rst_i              (sys_rst_i),
    .ext_trigger_pin_i      (ext_trigger_pin_i),
    .sample_clock_select_i  (ctrl_i.sample_clock_select),
    .edge_select_reg_i      (ctrl_i.edge_select_reg),
    .detected_edge_signal_o (edge_det)
  );

  // Prescaler divides system clock by 4..1024
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || !ctrl_i.count_run_bit)
      presc_reg <= 10'h000;
    else
      presc_reg <= presc_reg + 10'h001;
  end

  assign int_tick = ((presc_reg & presc_mask(ctrl_i.prescaler_select_reg)) ==
                     presc_mask(ctrl_i.prescaler_select_reg));
  assign cnt_clk  = ctrl_i.count_run_bit &&
                    ((ctrl_i.prescaler_select_reg == `ECCC_PSEL_EXT) ? edge_det
                                                                    : int_tick);
  assign max_val  = ctrl_i.width_select_bit ? `ECCC_WIDE_MAX : `ECCC_NARROW_MAX;
  assign match_a  = (cnt_next == width_mask(compare_reg_a_o, ctrl_i.width_select_bit));
  assign match_b  = !ctrl_i.shared_reg_func_sel &&
                    (cnt_next == width_mask(shared_capcomp_reg_o, ctrl_i.width_select_bit));
  assign cap_clr  = ctrl_i.count_run_bit && edge_det &&
                    ctrl_i.shared_reg_func_sel && ctrl_i.clear_on_shared;

  always_comb
  begin
    if (!started_reg || clr_pend_reg)
      cnt_next = `ECCC_ZERO;
    else if (cnt_reg == max_val)
      cnt_next = `ECCC_ZERO;
    else
      cnt_next = cnt_reg + 16'h0001;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      run_d_reg <= 1'b0;
    else
      run_d_reg <= ctrl_i.count_run_bit;
  end

  // Counter
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || !ctrl_i.count_run_bit)
    begin
      cnt_reg     <= `ECCC_ZERO;
      started_reg <= 1'b0;
    end
    else if (cnt_clk)
    begin
      cnt_reg     <= cnt_next;
      started_reg <= 1'b1;
    end
  end

  // Pending clear from match or capture
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || !ctrl_i.count_run_bit)
      clr_pend_reg <= 1'b0;
    else if (cap_clr ||
             (cnt_clk && started_reg &&
              ((match_a && ctrl_i.clear_on_match_a) ||
               (match_b && ctrl_i.clear_on_shared))))
      clr_pend_reg <= 1'b1;
    else if (cnt_clk)
      clr_pend_reg <= 1'b0;
  end

  // Match interrupts fire only on a counter clock tick, including wrap or clear to zero
  // Delayed one cycle so the pulse lines up with the matching counter_o
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      irq_a_reg     <= 1'b0;
      irq_b_reg     <= 1'b0;
      match_irq_a_o <= 1'b0;
      match_irq_b_o <= 1'b0;
    end
    else
    begin
      irq_a_reg     <= cnt_clk && started_reg && match_a;
      irq_b_reg     <= cnt_clk && started_reg && match_b;
      match_irq_a_o <= irq_a_reg;
      match_irq_b_o <= irq_b_reg;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      overflow_flag_o <= 1'b0;
    else if (cnt_clk && started_reg && !clr_pend_reg && cnt_reg == max_val)
      overflow_flag_o <= 1'b1;
    else if (ovf_clear_i)
      overflow_flag_o <= 1'b0;
  end

  // Compare registers written by software
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      compare_reg_a_o <= `ECCC_ZERO;
    else if (cmp_wr_i.wr_a)
      compare_reg_a_o <= cmp_wr_i.data;
  end

  // Captures hold until next trigger
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      shared_capcomp_reg_o <= `ECCC_ZERO;
    else if (ctrl_i.shared_reg_func_sel && ctrl_i.count_run_bit && edge_det)
      shared_capcomp_reg_o <= cnt_reg;
    else if (!ctrl_i.shared_reg_func_sel && cmp_wr_i.wr_b)
      shared_capcomp_reg_o <= cmp_wr_i.data;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      dedicated_capture_reg_o <= `ECCC_ZERO;
    else if (ctrl_i.count_run_bit && edge_det)
      dedicated_capture_reg_o <= cnt_reg;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      counter_o  <= `ECCC_ZERO;
      edge_irq_o <= 1'b0;
    end
    else
    begin
      counter_o  <= (ctrl_i.count_run_bit && run_d_reg) ? cnt_reg : `ECCC_ZERO;
      edge_irq_o <= edge_det;
    end
  end
endmodule : eccc_top

// ===== shared/eccc_defines.svh
`ifndef ECCC_DEFINES_SVH
`define ECCC_DEFINES_SVH

`define ECCC_CLK_PERIOD_NS    40
`define ECCC_FILT_STAGES      3
`define ECCC_PRESC_W          10
`define ECCC_PSEL_W           4
`define ECCC_SSEL_W           2
`define ECCC_CNT_W            16
`define ECCC_NARROW_MAX       16'h00ff
`define ECCC_WIDE_MAX         16'hffff
`define ECCC_ZERO             16'h0000
`define ECCC_PSEL_EXT         4'h9
`define ECCC_SDIV_32          10'h01f
`define ECCC_SDIV_64          10'h03f
`define ECCC_SDIV_128         10'h07f
`define ECCC_EDGE_FALL        2'h0
`define ECCC_EDGE_RISE        2'h1
`define ECCC_EDGE_BOTH        2'h2
`define ECCC_EDGE_NONE        2'h3

`endif

// ===== shared/eccc_pkg.sv
package eccc_pkg;
  typedef struct packed {
    logic        count_run_bit;
    logic        width_select_bit;
    logic [3:0]  prescaler_select_reg;
    logic [1:0]  sample_clock_select;
    logic [1:0]  edge_select_reg;
    logic        shared_reg_func_sel;
    logic        clear_on_match_a;
    logic        clear_on_shared;
  } eccc_ctrl_s;

  typedef struct packed {
    logic        wr_a;
    logic        wr_b;
    logic [15:0] data;
  } eccc_cmp_wr_s;
endpackage : eccc_pkg

// ===== hdl/eccc_edge_detect.sv
`include "eccc_defines.svh"

module eccc_edge_detect (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ext_trigger_pin_i,
  input  wire logic [1:0] sample_clock_select_i,
  input  wire logic [1:0] edge_select_reg_i,
  output logic            detected_edge_signal_o
);
  logic [2:0] sync_reg;
  logic [9:0] sdiv_reg;
  logic       smp_en;
  logic [2:0] filt_reg;
  logic       level_reg;
  logic       pin_lvl_reg;

  always_comb
  begin
    unique case (sample_clock_select_i)
      2'h0: smp_en = 1'b1;
      2'h1: smp_en = (sdiv_reg & `ECCC_SDIV_32) == 10'h000;
      2'h2: smp_en = (sdiv_reg & `ECCC_SDIV_64) == 10'h000;
      2'h3: smp_en = (sdiv_reg & `ECCC_SDIV_128) == 10'h000;
    endcase
  end

  // Pin synchroniser, three stages
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      sync_reg <= 3'h0;
    else
      sync_reg <= {sync_reg[1:0], ext_trigger_pin_i};
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      sdiv_reg <= 10'h000;
    else
      sdiv_reg <= sdiv_reg + 10'h001;
  end

  // Agreed pin level, kept so that a level keeps its full width
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      pin_lvl_reg <= 1'b0;
    else if (sync_reg[1] == sync_reg[2])
      pin_lvl_reg <= sync_reg[2];
  end

  // Level must stand three samples before it is accepted
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      filt_reg <= 3'h0;
    else if (smp_en)
      filt_reg <= {filt_reg[1:0], pin_lvl_reg};
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      level_reg              <= 1'b0;
      detected_edge_signal_o <= 1'b0;
    end
    else
    begin
      detected_edge_signal_o <= 1'b0;
      if (filt_reg == 3'h7 && !level_reg)
      begin
        level_reg              <= 1'b1;
        detected_edge_signal_o <= (edge_select_reg_i == `ECCC_EDGE_RISE) ||
                                  (edge_select_reg_i == `ECCC_EDGE_BOTH);
      end
      else if (filt_reg == 3'h0 && level_reg)
      begin
        level_reg              <= 1'b0;
        detected_edge_signal_o <= (edge_select_reg_i == `ECCC_EDGE_FALL) ||
                                  (edge_select_reg_i == `ECCC_EDGE_BOTH);
      end
    end
  end
endmodule : eccc_edge_detect

// ===== testbench/eccc_top_monitor.sv
module eccc_top_monitor (
  input wire logic                 mclk_i,
  input wire logic                 sys_rst_i,
  input wire eccc_pkg::eccc_ctrl_s ctrl_i,
  input wire logic                 ovf_clear_i,
  input wire logic [15:0]          counter_o,
  input wire logic [15:0]          compare_reg_a_o,
  input wire logic [15:0]          shared_capcomp_reg_o,
  input wire logic [15:0]          dedicated_capture_reg_o,
  input wire logic                 overflow_flag_o,
  input wire logic                 match_irq_a_o,
  input wire logic                 match_irq_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wm;
  assign wm = ctrl_i.width_select_bit ? 16'hffff : 16'h00ff;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  a_stop_zero: assert property ((!ctrl_i.count_run_bit) [*3] |-> counter_o == 16'h0000)
    else $error("counter not zero while stopped");
  a_narrow_limit: assert property (!ctrl_i.width_select_bit |-> counter_o[15:8] == 8'h00)
    else $error("narrow counter above its maximum");
  a_step_up: assert property ($changed(counter_o) |-> counter_o == 16'h0000
    || counter_o == (($past(counter_o) + 16'h0001) & wm)) else $error("counter jumped");
  a_ovf_sticky: assert property (overflow_flag_o && !ovf_clear_i |=> overflow_flag_o)
    else $error("overflow flag dropped by itself");
  a_ovf_clear: assert property ($fell(overflow_flag_o) |-> $past(ovf_clear_i))
    else $error("overflow flag cleared without request");
  a_match_a: assert property (match_irq_a_o |-> ((counter_o ^ compare_reg_a_o) & wm) == 0)
    else $error("match a without equal count");
  a_match_b: assert property (match_irq_b_o |-> !ctrl_i.shared_reg_func_sel
    && ((counter_o ^ shared_capcomp_reg_o) & wm) == 0) else $error("bad match b");
  a_irq_once: assert property (match_irq_a_o |=> !match_irq_a_o)
    else $error("match a repeated without increment");
  a_cap_hold: assert property ($changed(dedicated_capture_reg_o) |-> $past(ctrl_i.count_run_bit))
    else $error("capture changed while stopped");
endmodule : eccc_top_monitor
bind eccc_top eccc_top_monitor eccc_top_monitor_inst (.mclk_i, .sys_rst_i, .ctrl_i, .ovf_clear_i,
  .counter_o, .compare_reg_a_o, .shared_capcomp_reg_o, .dedicated_capture_reg_o,
  .overflow_flag_o, .match_irq_a_o, .match_irq_b_o);

// ===== testbench/eccc_pulse_src.sv
module eccc_pulse_src (
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_o = 1'b0;
  // Pulses with levels held whole clock periods
  task automatic send(input int n, input int hi, input int lo);
    repeat (n)
    begin
      pin_o = 1'b1;
      #(hi * 40);
      pin_o = 1'b0;
      #(lo * 40);
    end
  endtask : send
endmodule : eccc_pulse_src

// ===== testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   mclk_i = 1'b0;
  logic                   sys_rst_i = 1'b1;
  eccc_pkg::eccc_ctrl_s   ctrl = '0;
  eccc_pkg::eccc_cmp_wr_s cw = '0;
  logic                   ovf_clr = 1'b0;
  logic                   pin;
  logic [15:0]            cnt, cra, crs, crd, c1, c2;
  logic                   ovf, ia, ib, ie, seen_e;
  int                     fail_count = 0;
  int                     comparisons = 0;
  int                     n;
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (ie === 1'b1) seen_e <= 1'b1;
  eccc_top eccc_top_inst (.mclk_i, .sys_rst_i, .ctrl_i(ctrl), .cmp_wr_i(cw), .ovf_clear_i(ovf_clr),
    .ext_trigger_pin_i(pin), .counter_o(cnt), .compare_reg_a_o(cra), .shared_capcomp_reg_o(crs),
    .dedicated_capture_reg_o(crd), .overflow_flag_o(ovf), .match_irq_a_o(ia),
    .match_irq_b_o(ib), .edge_irq_o(ie));
  eccc_pulse_src eccc_pulse_src_inst (.pin_o(pin));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_i);
  endtask : cyc
  task automatic wt(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 5000)
    begin
      cyc(1);
      n++;
    end
    chk("wait", 16'(n == 5000), 16'h0000);
  endtask : wt
  task automatic wr(input logic b, input logic [15:0] d);
    cw = '{!b, b, d};
    cyc(1);
    cw = '0;
    cyc(1);
  endtask : wr
  task automatic start(input logic w, input logic [3:0] ps, input logic [1:0] es,
                       input logic [2:0] m);
    ctrl.count_run_bit = 1'b0;
    cyc(3);
    ctrl = '{1'b0, w, ps, 2'h0, es, m[2], m[1], m[0]};
    cyc(1);
    ctrl.count_run_bit = 1'b1;
  endtask : start
  task automatic cap3();
    for (int k = 0; k < 3; k++)
    begin
      c1 = c2;
      eccc_pulse_src_inst.send(1, 32, 32);
      c2 = crd;
    end
  endtask : cap3
  initial
  begin
    cyc(12);
    sys_rst_i = 1'b0;
    cyc(1);
    chk("counter", cnt, 16'h0000);
    chk("overflow", {15'h0000, ovf}, 16'h0000);
    for (int p = 0; p < 9; p++)
    begin
      ctrl.count_run_bit = 1'b0;
      c1 = (p == 0) ? 16'h0000 : (p == 1) ? 16'h00ff : 16'h0001;
      wr(1'b0, c1);
      chk("compare a", cra, c1);
      start(1'b0, 4'(p), 2'h3, 3'b010);
      wt(ia);
      cyc(1);
      wt(ia);
      chk("interval", 16'(n + 1), 16'((c1 + 1) * (4 << p)));
    end
    ctrl.count_run_bit = 1'b0;
    wr(1'b0, 16'h0002);
    wr(1'b1, 16'h0005);
    start(1'b0, 4'h0, 2'h3, 3'b000);
    wt(ia);
    chk("count at a", cnt, 16'h0002);
    wt(ib);
    chk("count at b", cnt, 16'h0005);
    wt(ovf);
    cyc(9);
    chk("overflow", {15'h0000, ovf}, 16'h0001);
    ovf_clr = 1'b1;
    cyc(1);
    ovf_clr = 1'b0;
    ctrl.count_run_bit = 1'b0;
    cyc(3);
    chk("overflow", {15'h0000, ovf}, 16'h0000);
    chk("stopped", cnt, 16'h0000);
    start(1'b1, 4'h0, 2'h3, 3'b000);
    cyc(1100);
    chk("wide", 16'(cnt > 16'h00ff), 16'h0001);
    c1 = cnt;
    ctrl.count_run_bit = 1'b1;
    cyc(8);
    chk("rerun", cnt - c1, 16'h0002);
    for (int e = 0; e < 4; e++)
    begin
      start(1'b0, 4'h9, 2'(e), 3'b000);
      cyc(3);
      eccc_pulse_src_inst.send(3, 3, 3);
      cyc(12);
      chk("events", cnt, (e == 2) ? 16'h0005 : (e == 3) ? 16'h0000 : 16'h0002);
    end
    start(1'b0, 4'h9, 2'h1, 3'b000);
    seen_e = 1'b0;
    eccc_pulse_src_inst.send(1, 2, 2);
    cyc(12);
    chk("short pulse", {15'h0000, seen_e}, 16'h0000);
    eccc_pulse_src_inst.send(1, 3, 3);
    cyc(12);
    chk("one edge", cnt, 16'h0000);
    chk("edge flag", {15'h0000, seen_e}, 16'h0001);
    start(1'b0, 4'h0, 2'h1, 3'b100);
    cap3();
    chk("period", c2 - c1, 16'h0010);
    chk("shared cap", crs, crd);
    cyc(100);
    chk("held", crd, c2);
    start(1'b0, 4'h0, 2'h1, 3'b101);
    cap3();
    chk("cleared", c2, c1);
    chk("small", 16'(c2 < 16'h0010), 16'h0001);
    test_done();
  end
  initial
  begin
    #2000000;
    fail_count++;
    test_done();
  end
endmodule : tb_top
